// >>> mcc_map.svh
`ifndef MCC_MAP_SVH
`define MCC_MAP_SVH
// How it works
// - One of six dim levels, one-hot on copy-output LED rows 2 to 7.
// - Configure mode, copy key held, source key 2..7 press sets dim level.
// - Talk to studio, talk to phones or slate also switch dim on.
// - Studio feed LED shows studio-follow setting; each press toggles it.
// - Mono latch bit picks held or toggle mono; mono LED shows it.
// - With auto dim off enabled, a level change clears an active key dim.
// - Configure mode dim LED shows the auto dim off enable.
// - Each comm key has a latch bit, shown on its LED, held or toggle.
// - Remote closures always act only while closed, latch bits ignored.
// - Copy and phones keys held two seconds restore defaults and exit.
// - Alternate page is shown only while the alt key is held.
// - Alt page talk-studio LED shows phones mix mode; its key toggles it.
// - Alt page slate LED shows tone enable; 50Hz tone while slate active.
// - Alt page phones LED 1 shows phones-follow; phones plus key 1 toggles.
// - Auto mute enabled mutes outputs while level knob sits at minimum.
// - Alt page phones plus key 5 toggles auto mute; LED 5 shows it.
// - Alt page phones LED 2 shows copy-follow; phones plus key 2 toggles.
// - Alt page phones LED 3 shows remote select enable, LED 4 its input.
// - Alt page phones plus key 4 swaps remote select input 6 and 7.
// - Remote select enabled takes remote input A to pick the source.
// - Configure entered by two second hold; function outputs but auto mute off, source and dim level still driven; LED flashes.
// - Remote select release reverts to the source chosen before it.

// Clock and timing figures.
`define MCC_CLK_KHZ 100000
`define MCC_HOLD_MS 2000
`define MCC_DEB_MS 10
`define MCC_TONE_HZ 50
`define MCC_BLINK_MS 250

// Positions in the key vector; source keys take positions 0 to 6.
`define MCC_K_COPY 7
`define MCC_K_PHONES 8
`define MCC_K_STUDIO 9
`define MCC_K_MONO 10
`define MCC_K_DIM 11
`define MCC_K_TS 12
`define MCC_K_TP 13
`define MCC_K_SLATE 14
`define MCC_K_ALT 15
`define MCC_K_CFG 16
`define MCC_K_REMA 17
`define MCC_K_REMB 18
`define MCC_NKEYS 19
`define MCC_PANEL_MASK 19'h1ffff

// Settings word fields; dim level takes bits 2:0.
`define MCC_S_STUDIO 3
`define MCC_S_MONO 4
`define MCC_S_ADO 5
`define MCC_S_LTS 6
`define MCC_S_LTP 7
`define MCC_S_LSL 8
`define MCC_S_TPMIX 9
`define MCC_S_TONE 10
`define MCC_S_HPF 11
`define MCC_S_CPF 12
`define MCC_S_RSEN 13
`define MCC_S_RS7 14
`define MCC_S_AMUTE 15
`define MCC_SET_DEFAULT 16'h0020

// APB register byte addresses.
`define MCC_A_SETTINGS 12'h000
`define MCC_A_STATUS 12'h004
`define MCC_A_CONTROL 12'h008
`endif

// >>> mcc_pkg.sv
package mcc_pkg;
    // Operating mode of the console.
    typedef enum logic [1:0] {
        MCC_NORMAL = 2'b01,
        MCC_CONFIG = 2'b10
    } mcc_mode_t;
    typedef logic [15:0] mcc_set_t;
endpackage : mcc_pkg

// >>> mcc_console_config.sv
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "mcc_map.svh"
module mcc_console_config
    import mcc_pkg::*;
#(
    parameter int DEB_CYC = `MCC_DEB_MS * `MCC_CLK_KHZ,
    parameter int HOLD_CYC = `MCC_HOLD_MS * `MCC_CLK_KHZ,
    parameter int TONE_CYC = `MCC_CLK_KHZ * 1000 / (2 * `MCC_TONE_HZ),
    parameter int BLINK_CYC = `MCC_BLINK_MS * `MCC_CLK_KHZ
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [6:0] source_select_keys,
    input wire logic copy_key,
    input wire logic headphone_select_key,
    input wire logic studio_feed_key,
    input wire logic mono_key,
    input wire logic dim_key,
    input wire logic talk_studio_key,
    input wire logic talk_phones_key,
    input wire logic slate_key,
    input wire logic alt_access_key,
    input wire logic configure_key,
    input wire logic remote_a,
    input wire logic remote_b,
    input wire logic level_moved,
    input wire logic level_at_min,
    output logic audio_on,
    output logic dim_on,
    output logic [2:0] dim_level,
    output logic mono_on,
    output logic talk_studio_on,
    output logic talk_phones_on,
    output logic slate_on,
    output logic tone_out,
    output logic mute_out,
    output logic [2:0] cr_source,
    output logic [15:0] settings,
    output logic [6:0] copy_led,
    output logic [6:0] phones_led,
    output logic studio_led,
    output logic mono_led,
    output logic dim_led,
    output logic [2:0] comm_led,
    output logic configure_led
);

    // Lowest numbered source key in a vector, or 7 when none.
    function automatic logic [2:0] first_key(input logic [6:0] k);
        logic [2:0] idx;
        idx = 3'h7;
        for (int i = 6; i >= 0; i--) begin
            if (k[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction : first_key

    // Dim level to LED rows 2..7 of the copy-output column.
    function automatic logic [6:0] dim_rows(input logic [2:0] lvl);
        logic [6:0] r;
        r = 7'h00;
        if (lvl < 3'h6) begin
            r = 7'(7'h02 << lvl);
        end
        return r;
    endfunction : dim_rows

    logic [`MCC_NKEYS-1:0] raw;
    logic [`MCC_NKEYS-1:0] s1_q;
    logic [`MCC_NKEYS-1:0] s2_q;
    logic [`MCC_NKEYS-1:0] samp_q;
    logic [`MCC_NKEYS-1:0] deb_q;
    logic [`MCC_NKEYS-1:0] prev_q;
    logic [`MCC_NKEYS-1:0] k;
    logic [`MCC_NKEYS-1:0] kp;
    logic [27:0] deb_cnt_q;
    logic [27:0] hold_cnt_q;
    logic [27:0] tone_cnt_q;
    logic [27:0] blink_cnt_q;
    logic hold_cond;
    logic hold_done;
    mcc_mode_t mode_q;
    mcc_set_t cur_q;
    mcc_set_t pend_q;
    logic lock_q;
    logic dim_q;
    logic mono_lat_q;
    logic ts_lat_q;
    logic tp_lat_q;
    logic sl_lat_q;
    logic [2:0] cr_src_q;
    logic tone_q;
    logic blink_q;
    logic in_cfg;
    logic alt;
    logic [2:0] skey;
    logic [2:0] rs_target;
    logic rs_act;
    logic ts_act;
    logic tp_act;
    logic sl_act;
    logic mono_act;
    logic [31:0] status;
    logic acc;

    // All keys and closures as one vector.
    assign raw = {remote_b, remote_a, configure_key, alt_access_key,
        slate_key, talk_phones_key, talk_studio_key, dim_key, mono_key,
        studio_feed_key, headphone_select_key, copy_key,
        source_select_keys};

    // Two-stage synchroniser for every key.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
        end
    end

    // Debounce: a level is accepted when two samples a tick apart agree.
    // This costs one counter for all keys instead of one per key.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            deb_cnt_q <= '0;
            samp_q <= '0;
            deb_q <= '0;
        end else if (deb_cnt_q == 28'(DEB_CYC - 1)) begin
            deb_cnt_q <= '0;
            samp_q <= s2_q;
            deb_q <= (deb_q & ~(samp_q ^ s2_q)) | (s2_q & ~(samp_q ^ s2_q));
        end else begin
            deb_cnt_q <= deb_cnt_q + 28'h1;
        end
    end

    // Press edges; software lockout silences the panel but not remotes.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prev_q <= '0;
        end else begin
            prev_q <= k;
        end
    end
    assign k = lock_q ? (deb_q & ~`MCC_PANEL_MASK) : deb_q;
    assign kp = k & ~prev_q;

    assign in_cfg = (mode_q == MCC_CONFIG);
    assign alt = k[`MCC_K_ALT];
    assign skey = first_key(kp[6:0]);

    // Hold timer: configure key in normal mode, copy plus
    // phones in configure mode.
    assign hold_cond = in_cfg ? (k[`MCC_K_COPY] & k[`MCC_K_PHONES])
                              : k[`MCC_K_CFG];
    assign hold_done = hold_cond && (hold_cnt_q == 28'(HOLD_CYC - 1));

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hold_cnt_q <= '0;
        end else if (!hold_cond || hold_done) begin
            hold_cnt_q <= '0;
        end else begin
            hold_cnt_q <= hold_cnt_q + 28'h1;
        end
    end

    // Mode sequencing; settings commit only on exit.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_q <= MCC_NORMAL;
            cur_q <= `MCC_SET_DEFAULT;
        end else begin
            unique case (mode_q)
                MCC_NORMAL: begin
                    if (hold_done) begin
                        mode_q <= MCC_CONFIG;
                    end
                end
                MCC_CONFIG: begin
                    if (hold_done) begin
                        cur_q <= `MCC_SET_DEFAULT;
                        mode_q <= MCC_NORMAL;
                    end else if (kp[`MCC_K_CFG]) begin
                        cur_q <= pend_q;
                        mode_q <= MCC_NORMAL;
                    end
                end
            endcase
        end
    end

    // Settings copy edited from the panel.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pend_q <= `MCC_SET_DEFAULT;
        end else if (!in_cfg) begin
            pend_q <= cur_q;
        end else if (hold_done) begin
            pend_q <= `MCC_SET_DEFAULT;
        end else if (!alt) begin
            if (k[`MCC_K_COPY] && skey != 3'h7 && skey != 3'h0) begin
                pend_q[2:0] <= skey - 3'h1;
            end
            if (kp[`MCC_K_STUDIO]) begin
                pend_q[`MCC_S_STUDIO] <= ~pend_q[`MCC_S_STUDIO];
            end
            if (kp[`MCC_K_MONO]) begin
                pend_q[`MCC_S_MONO] <= ~pend_q[`MCC_S_MONO];
            end
            if (kp[`MCC_K_DIM]) begin
                pend_q[`MCC_S_ADO] <= ~pend_q[`MCC_S_ADO];
            end
            if (kp[`MCC_K_TS]) begin
                pend_q[`MCC_S_LTS] <= ~pend_q[`MCC_S_LTS];
            end
            if (kp[`MCC_K_TP]) begin
                pend_q[`MCC_S_LTP] <= ~pend_q[`MCC_S_LTP];
            end
            if (kp[`MCC_K_SLATE]) begin
                pend_q[`MCC_S_LSL] <= ~pend_q[`MCC_S_LSL];
            end
        end else begin
            if (kp[`MCC_K_TS]) begin
                pend_q[`MCC_S_TPMIX] <= ~pend_q[`MCC_S_TPMIX];
            end
            if (kp[`MCC_K_SLATE]) begin
                pend_q[`MCC_S_TONE] <= ~pend_q[`MCC_S_TONE];
            end
            if (k[`MCC_K_PHONES]) begin
                if (kp[0]) begin
                    pend_q[`MCC_S_HPF] <= ~pend_q[`MCC_S_HPF];
                end
                if (kp[1]) begin
                    pend_q[`MCC_S_CPF] <= ~pend_q[`MCC_S_CPF];
                end
                if (kp[2]) begin
                    pend_q[`MCC_S_RSEN] <= ~pend_q[`MCC_S_RSEN];
                end
                if (kp[3]) begin
                    pend_q[`MCC_S_RS7] <= ~pend_q[`MCC_S_RS7];
                end
                if (kp[4]) begin
                    pend_q[`MCC_S_AMUTE] <= ~pend_q[`MCC_S_AMUTE];
                end
            end
        end
    end

    // Remote select target: source index 5 is input 6, index 6 input 7.
    assign rs_target = cur_q[`MCC_S_RS7] ? 3'h6 : 3'h5;
    assign rs_act = cur_q[`MCC_S_RSEN] & k[`MCC_K_REMA];

    // Dim latch: the dim key toggles it in normal mode; a level change clears it
    // only a key dim, never a comm dim.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dim_q <= 1'b0;
        end else if (in_cfg) begin
            dim_q <= dim_q;
        end else if (kp[`MCC_K_DIM]) begin
            dim_q <= ~dim_q;
        end else if (cur_q[`MCC_S_ADO] && dim_q && level_moved) begin
            dim_q <= 1'b0;
        end
    end

    // Latched states of mono and the comm keys; cleared when the latch
    // bit is off, so latching starts from off.
    always_ff @(posedge clk) begin
        if (sys_rst || in_cfg) begin
            mono_lat_q <= 1'b0;
            ts_lat_q <= 1'b0;
            tp_lat_q <= 1'b0;
            sl_lat_q <= 1'b0;
        end else begin
            mono_lat_q <= cur_q[`MCC_S_MONO] &
                (mono_lat_q ^ kp[`MCC_K_MONO]);
            ts_lat_q <= cur_q[`MCC_S_LTS] &
                (ts_lat_q ^ kp[`MCC_K_TS]);
            tp_lat_q <= cur_q[`MCC_S_LTP] &
                (tp_lat_q ^ kp[`MCC_K_TP]);
            sl_lat_q <= cur_q[`MCC_S_LSL] &
                (sl_lat_q ^ kp[`MCC_K_SLATE]);
        end
    end

    // Function activity; remote closures act only while present.
    assign mono_act = cur_q[`MCC_S_MONO] ? mono_lat_q : k[`MCC_K_MONO];
    assign ts_act = (cur_q[`MCC_S_LTS] ? ts_lat_q : k[`MCC_K_TS]) |
        (k[`MCC_K_REMA] & ~cur_q[`MCC_S_RSEN]);
    assign tp_act = (cur_q[`MCC_S_LTP] ? tp_lat_q : k[`MCC_K_TP]) |
        k[`MCC_K_REMB];
    assign sl_act = cur_q[`MCC_S_LSL] ? sl_lat_q : k[`MCC_K_SLATE];

    // Control room selection held aside so a remote select can revert.
    // The target key is unusable while remote select is on.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cr_src_q <= 3'h0;
        end else if (!in_cfg && skey != 3'h7 && !k[`MCC_K_PHONES] &&
                     !k[`MCC_K_COPY] && !rs_act &&
                     !(cur_q[`MCC_S_RSEN] && skey == rs_target)) begin
            cr_src_q <= skey;
        end
    end

    // Slate tone square wave, free running.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tone_cnt_q <= '0;
            tone_q <= 1'b0;
        end else if (tone_cnt_q == 28'(TONE_CYC - 1)) begin
            tone_cnt_q <= '0;
            tone_q <= ~tone_q;
        end else begin
            tone_cnt_q <= tone_cnt_q + 28'h1;
        end
    end

    // Flash timebase for the configure LED.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            blink_cnt_q <= '0;
            blink_q <= 1'b0;
        end else if (blink_cnt_q == 28'(BLINK_CYC - 1)) begin
            blink_cnt_q <= '0;
            blink_q <= ~blink_q;
        end else begin
            blink_cnt_q <= blink_cnt_q + 28'h1;
        end
    end

    // Function outputs; all on/off flags but mute_out off in configure mode, cr_source and dim_level still driven.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            audio_on <= 1'b0;
            dim_on <= 1'b0;
            mono_on <= 1'b0;
            talk_studio_on <= 1'b0;
            talk_phones_on <= 1'b0;
            slate_on <= 1'b0;
            tone_out <= 1'b0;
            mute_out <= 1'b0;
            cr_source <= 3'h0;
            dim_level <= 3'h0;
            settings <= '0;
        end else begin
            audio_on <= !in_cfg;
            dim_on <= !in_cfg && (dim_q || ts_act || tp_act || sl_act);
            mono_on <= !in_cfg && mono_act;
            talk_studio_on <= !in_cfg && ts_act;
            talk_phones_on <= !in_cfg && tp_act;
            slate_on <= !in_cfg && sl_act;
            tone_out <= !in_cfg && sl_act && cur_q[`MCC_S_TONE] &&
                tone_q;
            mute_out <= cur_q[`MCC_S_AMUTE] && level_at_min;
            cr_source <= rs_act ? rs_target : cr_src_q;
            dim_level <= cur_q[2:0];
            settings <= cur_q;
        end
    end

    // Panel LEDs: function state normally, settings in configure mode,
    // alt page only while alt is held.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            copy_led <= '0;
            phones_led <= '0;
            studio_led <= 1'b0;
            mono_led <= 1'b0;
            dim_led <= 1'b0;
            comm_led <= '0;
            configure_led <= 1'b0;
        end else if (!in_cfg) begin
            copy_led <= '0;
            phones_led <= '0;
            studio_led <= 1'b0;
            mono_led <= mono_act;
            dim_led <= dim_q || ts_act || tp_act || sl_act;
            comm_led <= {sl_act, tp_act, ts_act};
            configure_led <= 1'b0;
        end else if (alt) begin
            copy_led <= '0;
            phones_led <= {2'b00, pend_q[`MCC_S_AMUTE], pend_q[`MCC_S_RS7],
                pend_q[`MCC_S_RSEN], pend_q[`MCC_S_CPF],
                pend_q[`MCC_S_HPF]};
            studio_led <= 1'b0;
            mono_led <= 1'b0;
            dim_led <= 1'b0;
            comm_led <= {pend_q[`MCC_S_TONE], 1'b0,
                pend_q[`MCC_S_TPMIX]};
            configure_led <= blink_q;
        end else begin
            copy_led <= dim_rows(pend_q[2:0]);
            phones_led <= '0;
            studio_led <= pend_q[`MCC_S_STUDIO];
            mono_led <= pend_q[`MCC_S_MONO];
            dim_led <= pend_q[`MCC_S_ADO];
            comm_led <= {pend_q[`MCC_S_LSL], pend_q[`MCC_S_LTP],
                pend_q[`MCC_S_LTS]};
            configure_led <= blink_q;
        end
    end

    // Status word for software.
    assign status = {19'h0, rs_act, 1'b0, cr_source, 1'b0, slate_on,
        talk_phones_on, talk_studio_on, mono_on, dim_on, mode_q};

    // APB slave: zero wait states; read data captured in setup phase.
    assign acc = psel && penable;
    assign pready = 1'b1;
    assign pslverr = acc && paddr != `MCC_A_SETTINGS &&
        paddr != `MCC_A_STATUS && paddr != `MCC_A_CONTROL;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                `MCC_A_SETTINGS: prdata <= {16'h0, cur_q};
                `MCC_A_STATUS: prdata <= status;
                `MCC_A_CONTROL: prdata <= {31'h0, lock_q};
                default: prdata <= '0;
            endcase
        end
    end

    // Control register: bit 0 locks out the panel keys.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lock_q <= 1'b0;
        end else if (acc && pwrite && paddr == `MCC_A_CONTROL) begin
            lock_q <= pwdata[0];
        end
    end

endmodule : mcc_console_config

// >>> mcc_console_config_chk.sv
`timescale 1ns/100ps
module mcc_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic audio_on,
    input wire logic dim_on,
    input wire logic [2:0] dim_level,
    input wire logic mono_on,
    input wire logic talk_studio_on,
    input wire logic talk_phones_on,
    input wire logic slate_on,
    input wire logic tone_out,
    input wire logic mute_out,
    input wire logic [15:0] settings,
    input wire logic configure_led
);
    // Single clock domain.
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // No wait states; errors only off the map.
    chk_ready_always: assert property (pready)
        else $error("pready dropped");
    chk_err_unmapped: assert property (psel && penable && paddr > 12'h008
        |-> pslverr) else $error("unmapped access not refused");
    chk_err_mapped: assert property (psel && penable && paddr <= 12'h008 &&
        paddr[1:0] == 2'b00 |-> !pslverr) else $error("mapped refused");
    chk_dim_range: assert property (dim_level <= 3'h5)
        else $error("dim level out of range");
    // Dim may lag by one stage.
    chk_comm_dims: assert property (talk_studio_on || talk_phones_on ||
        slate_on |-> ##[0:1] dim_on) else $error("comm without dim");
    chk_mute_enable: assert property (mute_out |-> settings[15])
        else $error("mute while disabled");
    chk_tone_enable: assert property (tone_out |-> settings[10])
        else $error("tone while disabled");
    chk_cfg_quiet: assert property (!audio_on && !$past(audio_on)
        |-> !mono_on && !talk_studio_on && !slate_on && !tone_out)
        else $error("function in configure");
    // Settings move only on exit.
    chk_commit_exit: assert property ($changed(settings) &&
        !$past(sys_rst) && !$past(sys_rst, 2) |-> !$past(audio_on))
        else $error("settings moved early");
    chk_led_normal: assert property (audio_on && $past(audio_on)
        |-> !configure_led) else $error("lamp lit in normal");
endmodule : mcc_chk
bind mcc_console_config mcc_chk mcc_chk_inst (.clk, .sys_rst, .paddr,
    .psel, .penable, .pready, .pslverr, .audio_on, .dim_on, .dim_level,
    .mono_on, .talk_studio_on, .talk_phones_on, .slate_on, .tone_out,
    .mute_out, .settings, .configure_led);

// >>> mcc_operator.sv
`timescale 1ns/100ps
`include "mcc_map.svh"
module mcc_operator (
    input wire logic clk,
    output logic [`MCC_NKEYS-1:0] keys
);
    // Keys open at start.
    initial keys = '0;
    // A press bounces once; every change then holds past the debounce.
    task automatic set(input int idx, input logic v);
        @(posedge clk);
        keys[idx] <= v;
        if (v) begin
            @(posedge clk);
            keys[idx] <= 1'b0;
            @(posedge clk);
            keys[idx] <= 1'b1;
        end
        repeat (25) @(posedge clk);
    endtask : set
endmodule : mcc_operator

// >>> tb_mcc_console_config.sv
`timescale 1ns/100ps
`include "mcc_map.svh"
module tb_mcc_console_config;
    import mcc_pkg::*;
    typedef struct {logic [11:0] a; logic w; logic [31:0] d; logic e;} mcc_row_t;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic level_moved = 1'b0, level_at_min = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, audio_on, dim_on, mono_on, talk_studio_on;
    logic talk_phones_on, slate_on, tone_out, mute_out, studio_led, t0;
    logic mono_led, dim_led, configure_led;
    logic [2:0] dim_level, cr_source, comm_led;
    logic [15:0] settings;
    logic [6:0] copy_led, phones_led;
    logic [`MCC_NKEYS-1:0] keys;
    int n_errors = 0;
    int checks_done = 0;
    // Address, write, data, error expected.
    mcc_row_t rows [7] = '{'{12'h000, 1'b0, 32'h20, 1'b0},
        '{12'h004, 1'b0, 32'h1, 1'b0}, '{12'h008, 1'b1, 32'h1, 1'b0},
        '{12'h008, 1'b0, 32'h1, 1'b0}, '{12'h008, 1'b1, 32'h0, 1'b0},
        '{12'h00c, 1'b0, 32'h0, 1'b1}, '{12'h010, 1'b1, 32'hff, 1'b1}};
    // Short timings keep runs brief.
    mcc_console_config #(.DEB_CYC(4), .HOLD_CYC(50), .TONE_CYC(8),
        .BLINK_CYC(8)) mcc_console_config_inst (
        .clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .source_select_keys(keys[6:0]),
        .copy_key(keys[`MCC_K_COPY]),
        .headphone_select_key(keys[`MCC_K_PHONES]),
        .studio_feed_key(keys[`MCC_K_STUDIO]), .mono_key(keys[`MCC_K_MONO]),
        .dim_key(keys[`MCC_K_DIM]), .talk_studio_key(keys[`MCC_K_TS]),
        .talk_phones_key(keys[`MCC_K_TP]), .slate_key(keys[`MCC_K_SLATE]),
        .alt_access_key(keys[`MCC_K_ALT]), .configure_key(keys[`MCC_K_CFG]),
        .remote_a(keys[`MCC_K_REMA]), .remote_b(keys[`MCC_K_REMB]),
        .level_moved, .level_at_min, .audio_on, .dim_on, .dim_level,
        .mono_on, .talk_studio_on, .talk_phones_on, .slate_on, .tone_out,
        .mute_out, .cr_source, .settings, .copy_led, .phones_led,
        .studio_led, .mono_led, .dim_led, .comm_led, .configure_led);
    mcc_operator mcc_operator_inst (.clk, .keys);
    // 100 MHz clock.
    always #5 clk = ~clk;
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle
    task automatic key(input int k, input logic v);
        mcc_operator_inst.set(k, v);
    endtask : key
    task automatic tap(input int k);
        key(k, 1'b1);
        key(k, 1'b0);
    endtask : tap
    task automatic chkb(input logic got, input logic exp, input string m);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask : chkb
    task automatic chkw(input logic [31:0] got, input logic [31:0] exp,
        input string m);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %h", $time, m, got);
        end
    endtask : chkw
    // Setup, then access held until pready at an edge.
    task automatic apb(input logic [11:0] a, input logic w,
        input logic [31:0] d);
        @(posedge clk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude
    // Cuts a hang short.
    initial begin
        #100000;
        n_errors++;
        conclude();
    end
    // Samples read pre-edge values.
    initial begin
        idle(2);
        sys_rst <= 1'b0;
        idle(3);
        chkw({16'h0, settings}, 32'h20, "default settings");
        chkb(audio_on, 1'b1, "audio after reset");
        $display("test reset done");
        foreach (rows[i]) begin
            apb(rows[i].a, rows[i].w, rows[i].d);
            if (!rows[i].w)
                chkw(rd, rows[i].d, "read data");
            chkb(er, rows[i].e, "slave error");
        end
        $display("test registers done");
        // Lockout, dim latch, auto dim off.
        apb(12'h008, 1'b1, 32'h1);
        tap(`MCC_K_DIM);
        chkb(dim_on, 1'b0, "dim under lockout");
        apb(12'h008, 1'b1, 32'h0);
        tap(`MCC_K_DIM);
        chkb(dim_on, 1'b1, "dim latched");
        level_moved <= 1'b1;
        idle(20);
        level_moved <= 1'b0;
        idle(25);
        chkb(dim_on, 1'b0, "auto dim off");
        key(`MCC_K_TS, 1'b1);
        chkb(talk_studio_on, 1'b1, "talk held");
        chkb(dim_on, 1'b1, "talk dims");
        key(`MCC_K_TS, 1'b0);
        chkb(talk_studio_on, 1'b0, "talk released");
        for (int i = 0; i < 2; i++) begin
            key(`MCC_K_REMA + i, 1'b1);
            chkb(i ? talk_phones_on : talk_studio_on, 1'b1, "remote on");
            key(`MCC_K_REMA + i, 1'b0);
            chkb(i ? talk_phones_on : talk_studio_on, 1'b0, "remote off");
        end
        $display("test normal keys done");
        key(`MCC_K_CFG, 1'b1);
        idle(65);
        chkb(audio_on, 1'b0, "configure entry");
        key(`MCC_K_CFG, 1'b0);
        key(`MCC_K_COPY, 1'b1);
        tap(6);
        key(`MCC_K_COPY, 1'b0);
        chkw({25'h0, copy_led}, 32'h40, "dim row");
        tap(`MCC_K_STUDIO);
        chkb(studio_led, 1'b1, "studio follow");
        tap(`MCC_K_MONO);
        chkb(mono_led, 1'b1, "mono latch");
        chkb(dim_led, 1'b1, "auto dim off shown");
        tap(`MCC_K_TS);
        chkb(comm_led[0], 1'b1, "talk latch");
        key(`MCC_K_ALT, 1'b1);
        chkb(comm_led[0], 1'b0, "mix mode shown");
        tap(`MCC_K_SLATE);
        chkb(comm_led[2], 1'b1, "tone enable");
        key(`MCC_K_PHONES, 1'b1);
        tap(4);
        key(`MCC_K_PHONES, 1'b0);
        chkb(phones_led[4], 1'b1, "auto mute enable");
        key(`MCC_K_ALT, 1'b0);
        chkb(comm_led[2], 1'b0, "main page back");
        tap(`MCC_K_CFG);
        chkb(audio_on, 1'b1, "configure exit");
        chkw({16'h0, settings}, 32'h847d, "committed");
        chkw({29'h0, dim_level}, 32'h5, "dim level");
        $display("test configure done");
        tap(`MCC_K_MONO);
        chkb(mono_on, 1'b1, "mono latched");
        tap(`MCC_K_MONO);
        chkb(mono_on, 1'b0, "mono unlatched");
        tap(`MCC_K_TS);
        chkb(talk_studio_on, 1'b1, "talk latched");
        tap(`MCC_K_TS);
        key(`MCC_K_SLATE, 1'b1);
        chkb(slate_on, 1'b1, "slate held");
        t0 = tone_out;
        idle(8);
        chkb(tone_out, ~t0, "tone half period");
        key(`MCC_K_SLATE, 1'b0);
        level_at_min <= 1'b1;
        idle(25);
        chkb(mute_out, 1'b1, "auto mute");
        level_at_min <= 1'b0;
        idle(25);
        chkb(mute_out, 0, "auto mute off");
        $display("test latched use done");
        key(`MCC_K_CFG, 1'b1);
        idle(65);
        key(`MCC_K_CFG, 1'b0);
        key(`MCC_K_COPY, 1'b1);
        key(`MCC_K_PHONES, 1'b1);
        idle(70);
        chkb(audio_on, 1'b1, "factory exit");
        chkw({16'h0, settings}, 32'h20, "factory values");
        key(`MCC_K_COPY, 1'b0);
        key(`MCC_K_PHONES, 1'b0);
        $display("test factory done");
        conclude();
    end
endmodule : tb_mcc_console_config
